// File: core/wdt_edge_sync.sv
// Edge detector for the watchdog oscillator tick
`timescale 1ns/1ps
module wdt_edge_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Oscillator level in, tick out
  input wire logic oscIn,
  output logic tick
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } wdt_sync_type;
  wdt_sync_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.meta = oscIn;
    s_d.sync = s_q.meta;
    s_d.last = s_q.sync;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.sync & ~s_q.last;
endmodule : wdt_edge_sync

// File: core/wdt_pkg.sv
// Package of constants and types for the windowed watchdog timer
package wdt_pkg;
  // Register word offsets (byte addresses)
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_RESET_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;
  // Config field positions
  localparam int CFG_FORCE_EN_BIT = 7;
  localparam int CFG_WIN_DIS_BIT = 6;
  localparam int CFG_PRESCALE_BIT = 4;
  localparam int CFG_POST_MSB = 3;
  localparam logic [7:0] CFG_RESET = 8'hdf;
  localparam logic [7:0] CFG_WMASK = 8'hdf;
  // Reset control field positions
  localparam int RC_SOFT_EN_BIT = 5;
  localparam int RC_TIMEOUT_BIT = 4;
  localparam int RC_SLEEP_BIT = 3;
  localparam int RC_IDLE_BIT = 2;
  // Interrupt status bits
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_WAKE = 1;
  localparam int IRQ_WIN_FAULT = 2;
  localparam int IRQ_WIDTH = 3;
  // Prescaler ratios
  localparam int PRE_SHORT = 32;
  localparam int PRE_LONG = 128;
  localparam int PRE_WIDTH = 7;
  localparam int POST_WIDTH = 15;
  // Nominal oscillator and base periods
  localparam int OSC_KHZ = 32;
  localparam int BASE_SHORT_US = 1000;
  localparam int BASE_LONG_US = 4000;
  // Reset pulse length in system clocks
  localparam int RESET_PULSE_NS = 100;
  localparam int CLOCK_NS = 25;
  localparam int RESET_PULSE_CYC =
    (RESET_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS;

  typedef enum logic [1:0] {
    PM_RUN = 2'b00,
    PM_SLEEP = 2'b01,
    PM_IDLE = 2'b10
  } wdt_pmode_type;
endpackage : wdt_pkg

// File: core/wdt_scaler.sv
// Prescaler and postscaler counter chain
`timescale 1ns/1ps
module wdt_scaler #(
  parameter int PRE_W = wdt_pkg::PRE_WIDTH,
  parameter int POST_W = wdt_pkg::POST_WIDTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Control
  input wire logic clear,
  input wire logic tick,
  input wire logic preLong,
  input wire logic [3:0] postSel,
  // Status
  output logic expire,
  output logic inWindow
);
  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [POST_W:0] post;
    logic expire;
    logic inWindow;
  } wdt_scl_type;
  wdt_scl_type s_q, s_d;
  logic [PRE_W-1:0] preLast;
  logic [POST_W:0] postLast;
  logic [POST_W:0] winStart;

  always_comb begin
    preLast = preLong ? PRE_W'(wdt_pkg::PRE_LONG - 1) :
      PRE_W'(wdt_pkg::PRE_SHORT - 1); // [RULE2] [RULE3]
    postLast = (POST_W+1)'((1 << postSel) - 1); // [RULE4] [RULE5]
    // Final quarter starts at three quarters of the period
    winStart = (POST_W+1)'((3 << postSel) >> 2);
    s_d = s_q;
    s_d.expire = 1'b0;
    if (clear) begin
      s_d.pre = '0;
      s_d.post = '0;
    end else if (tick) begin
      if (s_q.pre >= preLast) begin
        s_d.pre = '0;
        if (s_q.post >= postLast) begin
          s_d.post = '0;
          s_d.expire = 1'b1;
        end else begin
          s_d.post = s_q.post + 1'b1;
        end
      end else begin
        s_d.pre = s_q.pre + 1'b1;
      end
    end
    // Short periods put the final quarter inside pre ticks
    if (postSel == 4'h0) begin
      s_d.inWindow = s_d.pre >= PRE_W'((preLast + 1) * 3 / 4); // [RULE18]
    end else if (postSel == 4'h1) begin
      // Two pre periods: final quarter is second half of the second
      s_d.inWindow = s_d.post[0] &&
        (s_d.pre >= PRE_W'((preLast + 1) / 2)); // [RULE18]
    end else begin
      s_d.inWindow = s_d.post >= winStart; // [RULE18]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_q <= '0; // [RULE6]
    end else begin
      s_q <= s_d;
    end
  end

  assign expire = s_q.expire;
  assign inWindow = s_q.inWindow;
endmodule : wdt_scaler

// File: core/wdt_top.sv
// Windowed watchdog timer with Avalon-MM register access
//
// Overview of operation
// RULE1 - Watchdog counts low-power RC ticks; oscillator runs whenever enabled.
// RULE2 - Prescaler divides by 128 when select is 1, else by 32.
// RULE3 - Nominal 32 kHz gives 1 ms or 4 ms base period.
// RULE4 - Four-bit postscaler field picks sixteen ratios up to 1:32768.
// RULE5 - Postscaler ratio equals two to the power of the field.
// RULE6 - Any device reset clears counter, prescaler and postscaler.
// RULE7 - Completed clock switch clears the counter chain.
// RULE8 - Entering or leaving sleep or idle clears the counter chain.
// RULE9 - Clear instruction in normal running clears the chain.
// RULE10 - Watchdog keeps counting in sleep/idle; timeout there wakes device.
// RULE11 - Timeout in normal running issues a device reset.
// RULE12 - Sleep and idle status bits stay set until software clears.
// RULE13 - Timeout flag set on timeout, cleared only by software.
// RULE14 - Force enable set keeps watchdog on; soft enable ignored.
// RULE15 - Force enable clear lets soft enable turn watchdog on, off.
// RULE16 - Soft enable bit clears on every device reset.
// RULE17 - Window-disable 1 selects normal mode, 0 window mode.
// RULE18 - Window mode: clear before final quarter causes watchdog reset.
// RULE19 - Config byte: bit7 force, bit6 window, bit4 pre, 3:0 post.
`timescale 1ns/1ps
module wdt_top #(
  parameter logic [7:0] CFG_INIT = wdt_pkg::CFG_RESET
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Core events
  input wire logic wdClearInstr,
  input wire logic powerSaveInstr,
  input wire logic powerSaveIdle,
  input wire logic wakeEvent,
  input wire logic clockSwitchDone,
  // Oscillator
  input wire logic lowPowerRcOsc,
  output logic lowPowerRcOscEn,
  // Results
  output logic wdResetReq,
  output logic wdWake,
  output logic powerSaveActive,
  output logic irq
);
  typedef struct packed {
    logic [7:0] cfg;
    logic softEn;
    logic timeoutFlag;
    logic sleepFlag;
    logic idleFlag;
    logic [2:0] irqStatus;
    logic [2:0] irqMask;
    wdt_pkg::wdt_pmode_type pmode;
    logic [31:0] rdata;
    logic ack;
    logic resetReq;
    logic [3:0] resetCnt;
    logic wake;
  } wdt_state_type;
  wdt_state_type s_q, s_d;

  logic tick;
  logic expire;
  logic inWindow;
  logic enabled;
  logic chainClear;
  logic winFault;
  logic wrHit;
  logic rdHit;
  logic enterPs;
  logic leavePs;
  logic [2:0] irqEvents;
  logic [31:0] wmask;

  // Oscillator edge and counter chain
  wdt_edge_sync u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .oscIn(lowPowerRcOsc),
    .tick(tick)
  );

  wdt_scaler u_scaler (
    .clock(clock),
    .rst_b(rst_b),
    .clear(chainClear),
    .tick(tick & enabled),
    .preLong(s_q.cfg[wdt_pkg::CFG_PRESCALE_BIT]),
    .postSel(s_q.cfg[wdt_pkg::CFG_POST_MSB:0]),
    .expire(expire),
    .inWindow(inWindow)
  );

  always_comb begin
    enabled = s_q.cfg[wdt_pkg::CFG_FORCE_EN_BIT] |
      s_q.softEn; // [RULE14] [RULE15]
    enterPs = powerSaveInstr && (s_q.pmode == wdt_pkg::PM_RUN);
    leavePs = (s_q.pmode != wdt_pkg::PM_RUN) && (wakeEvent || expire);
    winFault = wdClearInstr && (s_q.pmode == wdt_pkg::PM_RUN) && enabled &&
      !s_q.cfg[wdt_pkg::CFG_WIN_DIS_BIT] && !inWindow; // [RULE17] [RULE18]
    chainClear = clockSwitchDone || enterPs || leavePs || !enabled ||
      (wdClearInstr && s_q.pmode == wdt_pkg::PM_RUN) ||
      s_q.resetReq; // [RULE7] [RULE8] [RULE9]
    wrHit = write && !s_q.ack;
    rdHit = read && !s_q.ack;
    wmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
      {8{byteenable[1]}}, {8{byteenable[0]}}};
    irqEvents = 3'h0;
    irqEvents[wdt_pkg::IRQ_TIMEOUT] = expire;
    irqEvents[wdt_pkg::IRQ_WAKE] = leavePs;
    irqEvents[wdt_pkg::IRQ_WIN_FAULT] = winFault;

    s_d = s_q;
    s_d.ack = (read || write) && !s_q.ack;
    s_d.wake = 1'b0;
    // Register writes
    if (wrHit) begin
      case (address)
        wdt_pkg::ADDR_CONFIG: begin
          s_d.cfg = (s_q.cfg & ~(wmask[7:0] & wdt_pkg::CFG_WMASK)) |
            (writedata[7:0] & wmask[7:0] & wdt_pkg::CFG_WMASK); // [RULE19]
        end
        wdt_pkg::ADDR_RESET_CONTROL: begin
          if (byteenable[0]) begin
            s_d.softEn = writedata[wdt_pkg::RC_SOFT_EN_BIT]; // [RULE15]
            s_d.timeoutFlag = writedata[wdt_pkg::RC_TIMEOUT_BIT];
            s_d.sleepFlag = writedata[wdt_pkg::RC_SLEEP_BIT];
            s_d.idleFlag = writedata[wdt_pkg::RC_IDLE_BIT];
          end
        end
        wdt_pkg::ADDR_IRQ_STATUS: begin
          if (byteenable[0]) begin
            s_d.irqStatus = s_q.irqStatus & ~writedata[2:0];
          end
        end
        wdt_pkg::ADDR_IRQ_MASK: begin
          if (byteenable[0]) begin
            s_d.irqMask = writedata[2:0];
          end
        end
        default: begin
        end
      endcase
    end
    // Hardware sets win over software clears
    s_d.irqStatus = s_d.irqStatus | irqEvents;
    if (expire || winFault) begin
      s_d.timeoutFlag = 1'b1; // [RULE13]
    end
    // Power-save sequencing
    case (s_q.pmode)
      wdt_pkg::PM_RUN: begin
        if (enterPs) begin
          s_d.pmode = powerSaveIdle ? wdt_pkg::PM_IDLE : wdt_pkg::PM_SLEEP;
          if (powerSaveIdle) begin
            s_d.idleFlag = 1'b1; // [RULE12]
          end else begin
            s_d.sleepFlag = 1'b1; // [RULE12]
          end
        end
      end
      wdt_pkg::PM_SLEEP, wdt_pkg::PM_IDLE: begin
        if (leavePs) begin
          s_d.pmode = wdt_pkg::PM_RUN;
          s_d.wake = 1'b1; // [RULE10]
        end
      end
      default: begin
        s_d.pmode = wdt_pkg::PM_RUN;
      end
    endcase
    // Device reset request pulse
    if (s_q.resetCnt != 4'h0) begin
      s_d.resetCnt = s_q.resetCnt - 4'h1;
    end
    if ((expire && s_q.pmode == wdt_pkg::PM_RUN) || winFault) begin
      s_d.resetCnt = 4'(wdt_pkg::RESET_PULSE_CYC); // [RULE11] [RULE18]
    end
    s_d.resetReq = s_d.resetCnt != 4'h0;
    // Register reads
    if (rdHit) begin
      s_d.rdata = 32'h0;
      case (address)
        wdt_pkg::ADDR_CONFIG: s_d.rdata[7:0] = s_q.cfg;
        wdt_pkg::ADDR_RESET_CONTROL: begin
          s_d.rdata[wdt_pkg::RC_SOFT_EN_BIT] = s_q.softEn;
          s_d.rdata[wdt_pkg::RC_TIMEOUT_BIT] = s_q.timeoutFlag;
          s_d.rdata[wdt_pkg::RC_SLEEP_BIT] = s_q.sleepFlag;
          s_d.rdata[wdt_pkg::RC_IDLE_BIT] = s_q.idleFlag;
        end
        wdt_pkg::ADDR_IRQ_STATUS: s_d.rdata[2:0] = s_q.irqStatus;
        wdt_pkg::ADDR_IRQ_MASK: s_d.rdata[2:0] = s_q.irqMask;
        default: s_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_q <= '0; // [RULE16]
      s_q.cfg <= CFG_INIT;
    end else begin
      s_q <= s_d;
    end
  end

  assign readdata = s_q.rdata;
  assign waitrequest = (read || write) && !s_q.ack;
  assign lowPowerRcOscEn = enabled; // [RULE1]
  assign wdResetReq = s_q.resetReq;
  assign wdWake = s_q.wake;
  assign powerSaveActive = s_q.pmode != wdt_pkg::PM_RUN;
  assign irq = |(s_q.irqStatus & s_q.irqMask);
endmodule : wdt_top

// File: test/wdt_core_model.sv
// Core-side model: RC oscillator and instruction pulses
`timescale 1ns/1ps
module wdt_core_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Oscillator
  input wire logic oscEn,
  output logic lowPowerRcOsc,
  // Instruction and event pulses
  output logic wdClearInstr,
  output logic powerSaveInstr,
  output logic powerSaveIdle,
  output logic wakeEvent,
  output logic clockSwitchDone
);
  logic [2:0] oscCnt = 3'h0;
  initial begin
    {wdClearInstr, powerSaveInstr, powerSaveIdle} = 3'h0;
    {wakeEvent, clockSwitchDone} = 2'h0;
  end
  // Stands still low while disabled
  always @(posedge clock) begin
    oscCnt <= (rst_b && oscEn) ? oscCnt + 3'h1 : 3'h0;
  end
  assign lowPowerRcOsc = oscCnt[2];
  task automatic pulse(input int k, input logic idle);
    @(posedge clock);
    powerSaveIdle <= idle;
    case (k)
      0: wdClearInstr <= 1'b1;
      1: powerSaveInstr <= 1'b1;
      2: wakeEvent <= 1'b1;
      default: clockSwitchDone <= 1'b1;
    endcase
    @(posedge clock);
    {wdClearInstr, powerSaveInstr, wakeEvent, clockSwitchDone} <= 4'h0;
  endtask : pulse
endmodule : wdt_core_model

// File: test/wdt_properties.sv
// Concurrent checks on the watchdog top-level ports
`timescale 1ns/1ps
module wdt_properties (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Bus
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // Events and results
  input wire logic powerSaveInstr,
  input wire logic lowPowerRcOscEn,
  input wire logic wdResetReq,
  input wire logic wdWake,
  input wire logic powerSaveActive,
  input wire logic irq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  sequence sPulse;
    wdResetReq [*4] ##1 !wdResetReq;
  endsequence
  sequence sAnswer;
    waitrequest ##1 !waitrequest;
  endsequence
  a_reset_pulse:
    assert property ($rose(wdResetReq) |-> sPulse) else $error("pulse len");
  a_bus_wait:
    assert property ($rose(read || write) |-> sAnswer) else $error("wait");
  a_wake_single:
    assert property (wdWake |=> !wdWake) else $error("wake len");
  a_wake_exit:
    assert property ($fell(powerSaveActive) |-> wdWake) else $error("exit");
  a_sleep_noreset:
    assert property ($rose(wdResetReq) |-> !powerSaveActive)
    else $error("reset in sleep");
  a_enter_save:
    assert property (powerSaveInstr && !powerSaveActive |=> powerSaveActive)
    else $error("enter");
  a_reset_clean:
    assert property ($rose(rst_b) |-> !irq && !wdWake && !wdResetReq &&
      !powerSaveActive) else $error("reset state");
  a_needs_osc:
    assert property ($rose(wdResetReq) |-> $past(lowPowerRcOscEn))
    else $error("no osc");
endmodule : wdt_properties

bind wdt_top wdt_properties i_props (.clock, .rst_b, .read, .write,
  .waitrequest, .powerSaveInstr, .lowPowerRcOscEn, .wdResetReq, .wdWake,
  .powerSaveActive, .irq);

// File: test/windowed_watchdog_timer_tb.sv
// Testbench of the windowed watchdog timer
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errTotal++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module windowed_watchdog_timer_tb;
  localparam logic [3:0] ACF = wdt_pkg::ADDR_CONFIG;
  localparam logic [3:0] ARC = wdt_pkg::ADDR_RESET_CONTROL;
  localparam logic [3:0] AIS = wdt_pkg::ADDR_IRQ_STATUS;
  localparam logic [3:0] AIM = wdt_pkg::ADDR_IRQ_MASK;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rdv;
  logic waitrequest, lowPowerRcOscEn, wdResetReq, wdWake;
  logic powerSaveActive, irq, wdClearInstr, powerSaveInstr;
  logic powerSaveIdle, wakeEvent, clockSwitchDone, lowPowerRcOsc;
  int errTotal = 0;
  int compares = 0;
  int cyc, h;
  int hits = 0;
  int ed[3] = '{32, 64, 128};
  logic [7:0] cfgs[3] = '{8'hc0, 8'hc1, 8'hd0};
  always #12.5 clock = ~clock;
  always @(negedge clock) if (wdResetReq === 1'b1) hits++;
  wdt_top i_dut (.clock, .rst_b, .address, .read, .write,
    .byteenable(4'hf), .writedata, .readdata, .waitrequest, .wdClearInstr,
    .powerSaveInstr, .powerSaveIdle, .wakeEvent, .clockSwitchDone,
    .lowPowerRcOsc, .lowPowerRcOscEn, .wdResetReq, .wdWake,
    .powerSaveActive, .irq);
  wdt_core_model i_core (.clock, .rst_b, .oscEn(lowPowerRcOscEn),
    .lowPowerRcOsc, .wdClearInstr, .powerSaveInstr, .powerSaveIdle,
    .wakeEvent, .clockSwitchDone);
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rdv = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 20) begin
      errTotal++;
      stop_test();
    end
  endtask : acc
  task automatic waitHi(input int lim);
    cyc = 0;
    while (wdResetReq !== 1'b1 && wdWake !== 1'b1 && cyc < lim) begin
      @(negedge clock);
      cyc++;
    end
    if (cyc >= lim) begin
      errTotal++;
      stop_test();
    end
  endtask : waitHi
  initial begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    acc(0, ACF, 0);
    `CHK(rdv[7:0], wdt_pkg::CFG_RESET)
    acc(0, ARC, 0);
    `CHK(rdv[5], 1'b0)
    acc(0, 4'h2, 0);
    `CHK(rdv, 32'h0)
    acc(1, AIM, 32'h7);
    for (int i = 0; i < 3; i++) begin
      acc(1, ACF, {24'h0, cfgs[i]});
      i_core.pulse(3, 1'b0);
      waitHi(3000);
      `CHK(wdResetReq, 1'b1)
      `CHK(cyc > (ed[i] - 1) * 8 && cyc < (ed[i] + 2) * 8, 1'b1)
    end
    $display("done: timeout periods");
    acc(1, ACF, 32'h40);
    @(negedge clock);
    `CHK(lowPowerRcOscEn, 1'b0)
    acc(0, ARC, 0);
    `CHK(rdv[4], 1'b1)
    `CHK(irq, 1'b1)
    acc(1, AIS, 32'h7);
    acc(1, ARC, 0);
    @(negedge clock);
    `CHK(irq, 1'b0)
    acc(1, ARC, 32'h20);
    @(negedge clock);
    `CHK(lowPowerRcOscEn, 1'b1)
    acc(1, ACF, 32'hc0);
    acc(1, ARC, 0);
    @(negedge clock);
    `CHK(lowPowerRcOscEn, 1'b1)
    $display("done: enables and flags");
    i_core.pulse(3, 1'b0);
    h = hits;
    repeat (6) begin
      repeat (150) @(posedge clock);
      i_core.pulse(0, 1'b0);
    end
    `CHK(hits, h)
    acc(1, ACF, 32'h80);
    i_core.pulse(3, 1'b0);
    i_core.pulse(0, 1'b0);
    waitHi(20);
    `CHK(wdResetReq, 1'b1)
    acc(0, AIS, 0);
    `CHK(rdv[2], 1'b1)
    acc(1, AIM, 0);
    @(negedge clock);
    `CHK(irq, 1'b0)
    i_core.pulse(3, 1'b0);
    h = hits;
    repeat (225) @(posedge clock);
    i_core.pulse(0, 1'b0);
    repeat (20) @(posedge clock);
    `CHK(hits, h)
    $display("done: clear and window");
    acc(1, ACF, 32'hc0);
    for (int i = 0; i < 2; i++) begin
      acc(1, ARC, 0);
      i_core.pulse(3, 1'b0);
      repeat (100) @(posedge clock);
      i_core.pulse(1, i[0]);
      @(negedge clock);
      `CHK(powerSaveActive, 1'b1)
      h = hits;
      if (i == 1) i_core.pulse(2, 1'b0);
      waitHi(400);
      `CHK(wdWake, 1'b1)
      `CHK(powerSaveActive, 1'b0)
      `CHK(hits, h)
      if (i == 0) `CHK(cyc > 240, 1'b1)
      acc(0, ARC, 0);
      `CHK(rdv[3 - i], 1'b1)
    end
    $display("done: power save");
    acc(1, ARC, 32'h20);
    acc(0, ARC, 0);
    `CHK(rdv[5], 1'b1)
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    acc(0, ARC, 0);
    `CHK(rdv[5], 1'b0)
    acc(0, ACF, 0);
    `CHK(rdv[7:0], wdt_pkg::CFG_RESET)
    $display("done: reset in run");
    stop_test();
  end
endmodule : windowed_watchdog_timer_tb
